// File: shared/sms_defs.vh
`ifndef SMS_DEFS_VH
`define SMS_DEFS_VH

// Register byte offsets
`define SMS_ADDR_CTRL 4'h0
`define SMS_ADDR_DATA 4'h4
`define SMS_ADDR_STATUS 4'h8

// Control register fields
`define SMS_BIT_START 0
`define SMS_BIT_ABORT 1
`define SMS_MODE_LO 2
`define SMS_MODE_HI 3
`define SMS_CLK_LO 4
`define SMS_CLK_HI 6

// Status register fields
`define SMS_STAT_ACTIVE 3
`define SMS_STAT_SHIFT 2
`define SMS_STAT_FILL_HI 4'hF
`define SMS_STAT_FILL_LO 2'h3

// Transfer modes
`define SMS_MODE_TX 2'h0
`define SMS_MODE_RX 2'h1
`define SMS_MODE_TXRX 2'h2

// Clock select and divider
`define SMS_CLK_EXT 3'h7
`define SMS_CLK_RESET 3'h0
`define SMS_DIV_BASE 8'h02
`define SMS_DIV_ONE 8'h01

// Frame constants
`define SMS_LAST_BIT 3'h7
`define SMS_DUMMY_WORD 8'hFF
`define SMS_WORD_RESET 8'h00

`endif

// File: rtl/sms_shift_engine.v
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "sms_defs.vh"
// Overview of operation
// - Transmit bits change on falling clock edges; receive bits sampled on rising edges.
// - Two-bit mode field selects transmit, receive or transmit/receive.
// - Start bit set in transmit mode loads buffer into shifter, sent LSB first.
// - Moving the transmit word to the shifter empties the buffer and interrupts.
// - Internal clock transmit: clock stops after 8 bits until buffer written.
// - Output holds previous last bit from flag rising until first falling edge.
// - Start cleared while sending: finish the current word, then clear flag.
// - Abort bit stops the transfer at once and clears the flag.
// - External clock transmit with no new word: send dummy word, then stop.
// - Receive mode shifts input LSB first; after 8 bits buffer it, interrupt.
// - Internal clock receive: clock waits until software reads the buffer.
// - Start cleared while receiving: finish current word into buffer, clear flag.
// - Aborted reception leaves partial data unbuffered and invalid.
// - Mode change discards buffer contents; software ends transfer first.
// - Transmit/receive mode shifts both ways LSB first, buffers word, interrupts.
// - Internal clock transmit/receive waits for a read and a new write.
// - Start cleared in transmit/receive: finish word into buffer, clear flag.
// - After the end the last transmitted bit stays on the output.
// - Clock select 111 takes the external clock pin; others drive it.
// - Read-only status bit shows transfer active: 1 running, 0 done.
module sms_shift_engine (
    // System
    input wire clk,
    input wire rst,
    // Avalon-MM slave
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output reg waitrequest,
    // Serial clock pin
    input wire serialClockIn,
    output reg serialClockOut_q,
    output reg serialClockOe_q,
    // Serial data pins
    output reg serialOutputLine_q,
    input wire serialIn,
    // Word event
    output reg serialInterrupt_q
);

    localparam ST_IDLE = 3'b001;
    localparam ST_RUN = 3'b010;
    localparam ST_WAIT = 3'b100;

    reg [2:0] state_q;
    reg start_q;
    reg [1:0] mode_q;
    reg [2:0] clkSel_q;
    reg [7:0] dataBuf_q;
    reg txLoaded_q;
    reg rxUnread_q;
    reg activeFlag_q;
    reg dummy_q;
    reg [7:0] shift_q;
    reg [2:0] bitCnt_q;
    reg [7:0] divCnt_q;
    reg sckMeta_q;
    reg sckSync_q;
    reg sckPrev_q;
    reg sinMeta_q;
    reg sinSync_q;
    reg [31:0] rdMux;

    // Bus decode; an access acts only at the edge where waitrequest is low
    wire busReq = read | write;
    wire busTake = busReq & ~waitrequest;
    wire wrCtrl = busTake & write & byteenable[0] & (address == `SMS_ADDR_CTRL);
    wire wrData = busTake & write & byteenable[0] & (address == `SMS_ADDR_DATA);
    wire rdData = busTake & read & (address == `SMS_ADDR_DATA);
    wire abortReq = wrCtrl & writedata[`SMS_BIT_ABORT];
    wire [1:0] newMode = writedata[`SMS_MODE_HI:`SMS_MODE_LO];

    // Mode decode
    wire isTx = (mode_q == `SMS_MODE_TX);
    wire isRx = (mode_q == `SMS_MODE_RX);
    wire isTxRx = (mode_q == `SMS_MODE_TXRX);
    wire extClk = (clkSel_q == `SMS_CLK_EXT);
    wire running = (state_q == ST_RUN);

    // Conditions for the next word to go ahead
    wire nextReady = isTx ? txLoaded_q : (isRx ? ~rxUnread_q : (~rxUnread_q & txLoaded_q));
    wire canBegin = start_q & (isRx | ((isTx | isTxRx) & txLoaded_q));

    // Internal clock: half period doubles with each select step
    wire [7:0] halfCnt = `SMS_DIV_BASE << clkSel_q;
    wire divHit = (divCnt_q == (halfCnt - `SMS_DIV_ONE));

    // Serial clock edges, from the divider or from the synchronised pin
    wire intFall = ~extClk & running & divHit & serialClockOut_q;
    wire intRise = ~extClk & running & divHit & ~serialClockOut_q;
    wire extFall = extClk & running & sckPrev_q & ~sckSync_q;
    wire extRise = extClk & running & ~sckPrev_q & sckSync_q;
    wire fallEv = intFall | extFall;
    wire riseEv = intRise | extRise;
    wire lastRise = riseEv & (bitCnt_q == `SMS_LAST_BIT);
    wire [7:0] rxWord = {sinSync_q, shift_q[7:1]};

    // Read data selection; reserved status bits 7:4 and 1:0 read as ones, bits 31:8 as zeros
    always @* begin
        rdMux = 32'h0000_0000;
        case (address)
            `SMS_ADDR_CTRL: begin
                rdMux[`SMS_BIT_START] = start_q;
                rdMux[`SMS_MODE_HI:`SMS_MODE_LO] = mode_q;
                rdMux[`SMS_CLK_HI:`SMS_CLK_LO] = clkSel_q;
            end
            `SMS_ADDR_DATA: begin
                rdMux[7:0] = dataBuf_q;
            end
            `SMS_ADDR_STATUS: begin
                rdMux[7:4] = `SMS_STAT_FILL_HI;
                rdMux[`SMS_STAT_ACTIVE] = activeFlag_q;
                rdMux[`SMS_STAT_SHIFT] = running;
                rdMux[1:0] = `SMS_STAT_FILL_LO;
            end
            default: begin
                rdMux = 32'h0000_0000;
            end
        endcase
    end

    // Avalon slave handshake: one wait cycle, then the access is taken
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else if (busTake) begin
            waitrequest <= 1'b1;
        end else if (busReq) begin
            waitrequest <= 1'b0;
            readdata <= rdMux;
        end
    end

    // Pin synchronisers; logic looks at the second stage, plus a third clock stage for edges
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sckMeta_q <= 1'b1;
            sckSync_q <= 1'b1;
            sckPrev_q <= 1'b1;
            sinMeta_q <= 1'b0;
            sinSync_q <= 1'b0;
        end else begin
            sckMeta_q <= serialClockIn;
            sckSync_q <= sckMeta_q;
            sckPrev_q <= sckSync_q;
            sinMeta_q <= serialIn;
            sinSync_q <= sinMeta_q;
        end
    end

    // Control registers, shared buffer and shift engine
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IDLE;
            start_q <= 1'b0;
            mode_q <= `SMS_MODE_TX;
            clkSel_q <= `SMS_CLK_RESET;
            dataBuf_q <= `SMS_WORD_RESET;
            txLoaded_q <= 1'b0;
            rxUnread_q <= 1'b0;
            activeFlag_q <= 1'b0;
            dummy_q <= 1'b0;
            shift_q <= `SMS_WORD_RESET;
            bitCnt_q <= 3'h0;
            divCnt_q <= 8'h00;
            serialClockOut_q <= 1'b1;
            serialClockOe_q <= 1'b0;
            serialOutputLine_q <= 1'b1;
            serialInterrupt_q <= 1'b0;
        end else begin
            serialInterrupt_q <= 1'b0;
            // Pin is driven only while an internal rate is selected
            serialClockOe_q <= ~extClk;
            // Software side of the buffer; later hardware sets win
            if (rdData) begin
                rxUnread_q <= 1'b0;
            end
            if (wrData) begin
                dataBuf_q <= writedata[7:0];
                txLoaded_q <= 1'b1;
            end
            if (wrCtrl) begin
                start_q <= writedata[`SMS_BIT_START] & ~writedata[`SMS_BIT_ABORT];
                mode_q <= newMode;
                clkSel_q <= writedata[`SMS_CLK_HI:`SMS_CLK_LO];
                if (newMode != mode_q) begin
                    // Buffer is not kept across a mode change
                    dataBuf_q <= `SMS_WORD_RESET;
                    txLoaded_q <= 1'b0;
                    rxUnread_q <= 1'b0;
                end
            end
            if (abortReq) begin
                // Partial word is dropped, never reaches the buffer
                state_q <= ST_IDLE;
                activeFlag_q <= 1'b0;
                serialClockOut_q <= 1'b1;
                dummy_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_IDLE: begin
                        if (canBegin) begin
                            state_q <= ST_RUN;
                            activeFlag_q <= 1'b1;
                            bitCnt_q <= 3'h0;
                            divCnt_q <= 8'h00;
                            serialClockOut_q <= 1'b1;
                            dummy_q <= 1'b0;
                            if (~isRx) begin
                                shift_q <= dataBuf_q;
                                // A write in the same cycle keeps the buffer full
                                txLoaded_q <= wrData;
                                serialInterrupt_q <= isTx;
                            end
                        end
                    end
                    ST_RUN: begin
                        // Divider runs only while shifting, so the clock parks high
                        if (~extClk) begin
                            if (divHit) begin
                                divCnt_q <= 8'h00;
                                serialClockOut_q <= ~serialClockOut_q;
                            end else begin
                                divCnt_q <= divCnt_q + `SMS_DIV_ONE;
                            end
                        end
                        // Output only moves on a falling edge, so it keeps the old bit
                        if (fallEv & ~isRx) begin
                            serialOutputLine_q <= shift_q[0];
                        end
                        if (riseEv) begin
                            shift_q <= rxWord;
                            bitCnt_q <= bitCnt_q + 3'h1;
                        end
                        if (lastRise) begin
                            if (~isTx) begin
                                dataBuf_q <= rxWord;
                                rxUnread_q <= 1'b1;
                                serialInterrupt_q <= 1'b1;
                            end
                            if (~start_q | dummy_q) begin
                                // Word is complete; output line left as is
                                state_q <= ST_IDLE;
                                activeFlag_q <= 1'b0;
                                dummy_q <= 1'b0;
                            end else if (extClk & isTx & ~txLoaded_q) begin
                                // Late software: the far clock cannot be held
                                shift_q <= `SMS_DUMMY_WORD;
                                dummy_q <= 1'b1;
                            end else if ((extClk & ~isTx) | (isTx & txLoaded_q)) begin
                                // Loaded transmit word or external clock rolls on; the external case relies on timely software
                                if (~isRx) begin
                                    shift_q <= dataBuf_q;
                                    txLoaded_q <= wrData;
                                    serialInterrupt_q <= 1'b1;
                                end
                            end else begin
                                state_q <= ST_WAIT;
                            end
                        end
                    end
                    ST_WAIT: begin
                        if (~start_q) begin
                            state_q <= ST_IDLE;
                            activeFlag_q <= 1'b0;
                        end else if (nextReady) begin
                            // Clock restarts from high with a fresh divider
                            state_q <= ST_RUN;
                            bitCnt_q <= 3'h0;
                            divCnt_q <= 8'h00;
                            if (~isRx) begin
                                shift_q <= dataBuf_q;
                                txLoaded_q <= wrData;
                                serialInterrupt_q <= isTx;
                            end
                        end
                    end
                    default: begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// File: sim/sms_shift_engine_sva.sv
`timescale 1ns/1ps
module sms_shift_engine_sva (
    // System
    input wire clk,
    input wire rst,
    // Register bus
    input wire [3:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire [31:0] readdata,
    input wire waitrequest,
    // Serial pins
    input wire serialClockIn,
    input wire serialClockOut_q,
    input wire serialClockOe_q,
    input wire serialOutputLine_q,
    input wire serialIn,
    input wire serialInterrupt_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Bus answers after one wait cycle, for one cycle only
    property p_wait_one;
        (read || write) && waitrequest |=> !waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer late");
    property p_wait_drop;
        !waitrequest |=> waitrequest;
    endproperty
    a_wait_drop: assert property (p_wait_drop) else $error("answer too long");
    // Status constant fields
    property p_stat_ones;
        read && !waitrequest && address == 4'h8 |-> readdata[31:4] == 28'h000_000F
            && readdata[1:0] == 2'h3;
    endproperty
    a_stat_ones: assert property (p_stat_ones) else $error("status fields");
    // Abort is a command, never read back
    property p_abort_rd0;
        read && !waitrequest && address == 4'h0 |-> !readdata[1];
    endproperty
    a_abort_rd0: assert property (p_abort_rd0) else $error("abort reads 1");
    // Clock select 7 hands the pin to the outside
    property p_ext_oe;
        write && !waitrequest && address == 4'h0 && byteenable[0]
            && writedata[6:4] == 3'h7 |-> ##[1:2] !serialClockOe_q;
    endproperty
    a_ext_oe: assert property (p_ext_oe) else $error("pin still driven");
    property p_int_pulse;
        serialInterrupt_q |=> !serialInterrupt_q;
    endproperty
    a_int_pulse: assert property (p_int_pulse) else $error("interrupt held");
    // Data moves only while the driven clock is low, so it holds over rises
    property p_dout_low;
        $changed(serialOutputLine_q) |-> !serialClockOut_q || !serialClockOe_q;
    endproperty
    a_dout_low: assert property (p_dout_low) else $error("data moved high");
    // Half period of the internal clock is at least two cycles
    property p_clk_half;
        serialClockOe_q && $changed(serialClockOut_q) |=> $stable(serialClockOut_q);
    endproperty
    a_clk_half: assert property (p_clk_half) else $error("clock glitch");
endmodule
bind sms_shift_engine sms_shift_engine_sva u_sva (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .serialClockIn(serialClockIn),
    .serialClockOut_q(serialClockOut_q), .serialClockOe_q(serialClockOe_q),
    .serialOutputLine_q(serialOutputLine_q), .serialIn(serialIn),
    .serialInterrupt_q(serialInterrupt_q));

// File: sim/sms_serial_partner.sv
`timescale 1ns/1ps
module sms_serial_partner (
    // Pins of the block
    input wire clkOut,
    input wire clkOe,
    input wire dataOut,
    output reg dataIn,
    output wire clkPin,
    // Bench side
    input wire [7:0] txWord,
    input wire extRun
);
    reg extClk = 1'b1;
    reg [2:0] cnt = 3'h0;
    reg [7:0] sh = 8'h00;
    reg [7:0] got [$];
    // Pulled high when undriven, so the clock parks high
    assign clkPin = clkOe ? clkOut : extClk;
    // The link clock runs only within one frame
    always @(posedge extRun) begin
        repeat (8) begin
            #100 extClk = 1'b0;
            #100 extClk = 1'b1;
        end
    end
    // Next bit on the leading edge, held until the next one
    always @(negedge clkPin) dataIn <= txWord[cnt];
    // Capture on the trailing edge, LSB first
    always @(posedge clkPin) begin
        sh = {dataOut, sh[7:1]};
        cnt = cnt + 3'h1;
        if (cnt == 3'h0) got.push_back(sh);
    end
    initial dataIn = 1'b0;
endmodule

// File: sim/sms_shift_engine_test.sv
`timescale 1ns/1ps
module sms_shift_engine_test;
    reg clk;
    reg rst;
    reg [3:0] address;
    reg read;
    reg write;
    reg [31:0] writedata;
    wire [31:0] readdata;
    wire waitrequest;
    wire clkPin;
    wire clkOut;
    wire clkOe;
    wire dOut;
    wire dIn;
    wire irq;
    reg [7:0] txWord;
    reg extRun;
    reg [31:0] seed;
    reg [31:0] q;
    reg [7:0] w0;
    reg [7:0] w1;
    reg [7:0] expQ [$];
    integer err_total;
    integer cmp_count;
    integer intCount;
    sms_shift_engine DUT (.clk(clk), .rst(rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
        .waitrequest(waitrequest), .serialClockIn(clkPin), .serialClockOut_q(clkOut),
        .serialClockOe_q(clkOe), .serialOutputLine_q(dOut), .serialIn(dIn),
        .serialInterrupt_q(irq));
    sms_serial_partner P (.clkOut(clkOut), .clkOe(clkOe), .dataOut(dOut), .dataIn(dIn),
        .clkPin(clkPin), .txWord(txWord), .extRun(extRun));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Interrupt is a one-cycle pulse; count so bus cycles never miss one
    always @(posedge clk) if (irq === 1'b1) intCount = intCount + 1;
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task finish_test;
        $display("errors %0d compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task tmo;
        err_total = err_total + 1;
        finish_test;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low, then released
    task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= ~wr;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n = n + 1;
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 20) tmo;
        @(posedge clk);
    endtask
    task waitInt(input integer target);
        integer n;
        for (n = 0; intCount < target; n = n + 1) begin
            if (n > 2000) tmo;
            @(posedge clk);
        end
    endtask
    task waitIdle;
        integer n;
        q = 32'h0000_0008;
        for (n = 0; q[3] !== 1'b0; n = n + 1) begin
            if (n > 300) tmo;
            bus(0, 4'h8, 0);
        end
    endtask
    initial begin
        rst = 1'b1;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        txWord = 8'h00;
        extRun = 1'b0;
        seed = 6068;
        err_total = 0;
        cmp_count = 0;
        intCount = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, 4'h8, 0);
        chk(q, 32'h0000_00F3);
        bus(0, 4'h0, 0);
        chk(q, 32'h0);
        bus(0, 4'hC, 0);
        chk(q, 32'h0);
        // Two words, the second late so the internal clock must wait
        // Pin settling at time zero looks like a rise to the partner
        P.cnt = 3'h0;
        w0 = rnd();
        w1 = rnd();
        expQ.push_back(w0);
        expQ.push_back(w1);
        bus(1, 4'h4, {24'h0, w0});
        bus(1, 4'h0, 32'h0000_0011);
        waitInt(1);
        repeat (150) @(posedge clk);
        chk(clkOut, 1);
        chk(P.got.size(), 1);
        bus(1, 4'h4, {24'h0, w1});
        waitInt(2);
        bus(1, 4'h0, 32'h0000_0010);
        waitIdle;
        chk(P.got.pop_front(), expQ.pop_front());
        chk(P.got.pop_front(), expQ.pop_front());
        chk(dOut, w1[7]);
        // Receive; the clock waits until the word is read
        P.cnt = 3'h0;
        txWord <= rnd();
        bus(1, 4'h0, 32'h0000_0015);
        waitInt(3);
        repeat (100) @(posedge clk);
        chk(clkOut, 1);
        bus(1, 4'h0, 32'h0000_0014);
        bus(0, 4'h4, 0);
        chk(q, {24'h0, txWord});
        waitIdle;
        // Full duplex with start dropped at once; mode set first, then data
        P.cnt = 3'h0;
        P.got.delete();
        w0 = rnd();
        txWord <= rnd();
        bus(1, 4'h0, 32'h0000_0018);
        bus(1, 4'h4, {24'h0, w0});
        bus(1, 4'h0, 32'h0000_0019);
        bus(1, 4'h0, 32'h0000_0018);
        waitIdle;
        bus(0, 4'h4, 0);
        chk(q, {24'h0, txWord});
        chk(P.got.pop_front(), w0);
        // Abort in mid-word
        bus(1, 4'h0, 32'h0000_0010);
        bus(1, 4'h4, {24'h0, rnd()});
        bus(1, 4'h0, 32'h0000_0011);
        repeat (20) @(posedge clk);
        bus(1, 4'h0, 32'h0000_0012);
        bus(0, 4'h8, 0);
        chk(q[3], 0);
        // Receive on the external link clock
        P.cnt = 3'h0;
        txWord <= rnd();
        w1 = intCount;
        bus(1, 4'h0, 32'h0000_0075);
        extRun <= 1'b1;
        waitInt(w1 + 1);
        bus(1, 4'h0, 32'h0000_0074);
        bus(0, 4'h4, 0);
        chk(q, {24'h0, txWord});
        // Start dropped: the far clock must finish one more word
        extRun <= 1'b0;
        @(posedge clk);
        extRun <= 1'b1;
        waitIdle;
        // External transmit with no second word: a dummy word, then stop
        P.cnt = 3'h0;
        P.got.delete();
        w0 = rnd();
        bus(1, 4'h0, 32'h0000_0070);
        bus(1, 4'h4, {24'h0, w0});
        extRun <= 1'b0;
        bus(1, 4'h0, 32'h0000_0071);
        extRun <= 1'b1;
        repeat (90) @(posedge clk);
        extRun <= 1'b0;
        @(posedge clk);
        extRun <= 1'b1;
        waitIdle;
        chk(P.got.pop_front(), w0);
        chk(P.got.pop_front(), 8'hFF);
        finish_test;
    end
endmodule
